// File: verilog/csfp_pkg.sv
// Package for the core status flags and pointers block.
// Assumes a single core clock and a synchronous active-high reset.
// Overview of operation
// [RULE1] Carry set on add carry-out or subtract without borrow, else clear.
// [RULE2] Half carry set on low-nibble carry or no nibble borrow, else clear.
// [RULE3] Zero flag set when the operation result is zero, else cleared. Rotates leave it unchanged here.
// [RULE4] Overflow set when carry into MSB differs from carry out of MSB.
// [RULE5] Sign-xor flag is overflow XOR result MSB.
// [RULE6] Subtract without borrow loads chained-zero flag with the zero flag.
// [RULE7] Subtract-with-borrow ANDs chained zero with zero; others keep it.
// [RULE8] Watchdog flag set by expiry, cleared by reset, clear-watchdog, halt.
// [RULE9] Sleep flag set by halt, cleared by reset or clear-watchdog.
// [RULE10] Writes to the flags register leave watchdog and sleep bits alone.
// [RULE11] Rotate through carry shifts old carry in and outgoing bit to carry.
// [RULE12] Calls and interrupts push only return address, never the flags.
// [RULE13] One bank-select bit, reset zero, picks jump bank; others read 0.
// [RULE14] Low PC write jumps within the current page with one dummy cycle.
// [RULE15] Table read keeps high byte in latch, low byte to destination.
// [RULE16] Extended address: upper bits are sector, low eight are location.
// [RULE17] No register-to-register move; transfers pass via the accumulator.
// [RULE18] Indirect port one: high pointer picks sector, low picks location.
// [RULE19] Indirect port read as register gives zero; writes do nothing.
package csfp_pkg;
  localparam int          DATA_W     = 8;
  localparam int          FLAG_C     = 0;
  localparam int          FLAG_AC    = 1;
  localparam int          FLAG_Z     = 2;
  localparam int          FLAG_OV    = 3;
  localparam int          FLAG_PDF   = 4;
  localparam int          FLAG_TO    = 5;
  localparam int          FLAG_CZ    = 6;
  localparam int          FLAG_SC    = 7;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  FLAGS_WMSK = 8'hCF;
  localparam logic [7:0]  BANK_RST   = 8'h00;
  localparam logic [7:0]  IND_READ   = 8'h00;
  localparam logic [1:0]  JUMP_DUMMY = 2'h1;

  typedef enum logic [3:0] {
    CSFP_OP_NONE = 4'h0,
    CSFP_OP_ADD  = 4'h1,
    CSFP_OP_ADC  = 4'h2,
    CSFP_OP_SUB  = 4'h3,
    CSFP_OP_SBC  = 4'h4,
    CSFP_OP_LOG  = 4'h5,
    CSFP_OP_RLC  = 4'h6,
    CSFP_OP_RRC  = 4'h7,
    CSFP_OP_MOV  = 4'h8
  } csfp_op_t;

  typedef enum logic [1:0] {
    CSFP_ST_RUN   = 2'b00,
    CSFP_ST_DUMMY = 2'b01
  } csfp_state_t;
endpackage

// File: verilog/csfp_alu.sv
// Combinational ALU with flag generation for the flags datapath.
// Assumes operands are stable for the cycle in which the op is issued.
`timescale 1ns/10ps
module csfp_alu
  import csfp_pkg::*;
(
  input  wire csfp_op_t   op,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic       carry_in,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            half_carry,
  output logic            ovf,
  output logic            is_zero,
  output logic            flag_upd
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b_eff;
  logic       cin;
  logic       c7;

  always_comb begin
    b_eff = opb;
    cin   = 1'b0;
    unique case (op)
      CSFP_OP_ADC: cin = carry_in;
      // Subtract as A + ~B + 1, so carry out means no borrow
      CSFP_OP_SUB: begin
        b_eff = ~opb;
        cin   = 1'b1;
      end
      CSFP_OP_SBC: begin
        b_eff = ~opb;
        cin   = carry_in;
      end
      default: cin = 1'b0;
    endcase
    sum  = {1'b0, opa} + {1'b0, b_eff} + {8'h00, cin};
    nib  = {1'b0, opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    c7   = opa[7] ^ b_eff[7] ^ sum[7];
    result     = sum[7:0];
    carry_out  = sum[8];
    half_carry = nib[4];
    ovf        = c7 ^ sum[8];
    flag_upd   = 1'b1;
    unique case (op)
      CSFP_OP_LOG: result = opa & opb;
      CSFP_OP_RLC: begin
        result    = {opa[6:0], carry_in};
        carry_out = opa[7];
      end
      CSFP_OP_RRC: begin
        result    = {carry_in, opa[7:1]};
        carry_out = opa[0];
      end
      CSFP_OP_MOV: result = opa;
      CSFP_OP_NONE: flag_upd = 1'b0;
      default: flag_upd = 1'b1;
    endcase
    is_zero = (result == 8'h00);
  end
endmodule

// File: verilog/csfp_core.sv
// Status flags, bank pointer, PC low, table pointers, sector addressing.
// Assumes the decoder issues one op per cycle and holds off during a
// jump dummy cycle (stall output).
`timescale 1ns/10ps
module csfp_core
  import csfp_pkg::*;
#(
  parameter int SECT_W = 2
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire csfp_op_t          alu_op,
  input  wire logic [7:0]        opa,
  input  wire logic [7:0]        opb,
  input  wire logic              acc_write,
  input  wire logic              wdt_expired,
  input  wire logic              clear_watchdog_instruction_instr,
  input  wire logic              halt_instr,
  input  wire logic              flags_wr,
  input  wire logic [7:0]        flags_wdata,
  input  wire logic              bank_wr,
  input  wire logic [7:0]        bank_wdata,
  input  wire logic              pcl_wr,
  input  wire logic [7:0]        pcl_wdata,
  input  wire logic [7:0]        pc_high,
  input  wire logic              table_pointer_low_wr,
  input  wire logic              table_pointer_high_wr,
  input  wire logic [7:0]        tbl_wdata,
  input  wire logic              tbl_read,
  input  wire logic [15:0]       prog_word,
  input  wire logic              ptr1l_wr,
  input  wire logic              ptr1h_wr,
  input  wire logic [7:0]        ptr_wdata,
  input  wire logic              ind1_access,
  input  wire logic              ind_as_reg_rd,
  input  wire logic              ext_access,
  input  wire logic [SECT_W+7:0] ext_addr,
  output logic [7:0]             core_flags_reg,
  output logic [7:0]             program_bank_select_reg,
  output logic [7:0]             acc_r,
  output logic                   jump_r,
  output logic [15:0]            jump_target_r,
  output logic                   stall_r,
  output logic [15:0]            table_addr_r,
  output logic [7:0]             table_high_latch,
  output logic [7:0]             table_low_r,
  output logic                   table_low_vld_r,
  output logic [SECT_W-1:0]      dmem_sector_r,
  output logic [7:0]             dmem_loc_r,
  output logic                   dmem_sel_r,
  output logic [7:0]             ind_read_r
);
  logic [7:0]  result;
  logic        carry_out;
  logic        half_carry;
  logic        ovf;
  logic        is_zero;
  logic        flag_upd;
  logic [7:0]  flags_nxt;
  logic [7:0]  table_pointer_low;
  logic [7:0]  table_pointer_high;
  logic [7:0]  pointer_one_low;
  logic [7:0]  pointer_one_high;
  csfp_state_t state_r;

  csfp_alu u_alu (
    .op         (alu_op),
    .opa        (opa),
    .opb        (opb),
    .carry_in   (core_flags_reg[FLAG_C]),
    .result     (result),
    .carry_out  (carry_out),
    .half_carry (half_carry),
    .ovf        (ovf),
    .is_zero    (is_zero),
    .flag_upd   (flag_upd)
  );

  // Flags: ALU update first, then software write over writable bits
  always_comb begin
    flags_nxt = core_flags_reg;
    if (flag_upd) begin
      unique case (alu_op)
        CSFP_OP_LOG, CSFP_OP_MOV: begin
          flags_nxt[FLAG_Z] = is_zero; // [RULE3]
        end
        CSFP_OP_RLC, CSFP_OP_RRC: begin
          flags_nxt[FLAG_C] = carry_out; // [RULE11]
        end
        default: begin
          flags_nxt[FLAG_C]  = carry_out;  // [RULE1]
          flags_nxt[FLAG_AC] = half_carry; // [RULE2]
          flags_nxt[FLAG_Z]  = is_zero;    // [RULE3]
          flags_nxt[FLAG_OV] = ovf;        // [RULE4]
          flags_nxt[FLAG_SC] = ovf ^ result[7]; // [RULE5]
        end
      endcase
      if (alu_op == CSFP_OP_SUB)
        flags_nxt[FLAG_CZ] = is_zero; // [RULE6]
      else if (alu_op == CSFP_OP_SBC)
        flags_nxt[FLAG_CZ] = core_flags_reg[FLAG_CZ] & is_zero; // [RULE7]
    end
    // Watchdog and sleep bits are masked out of writes
    if (flags_wr)
      flags_nxt = (flags_wdata & FLAGS_WMSK) |
                  (flags_nxt & ~FLAGS_WMSK); // [RULE10]
    // Expiry wins over a clearing instruction in the same cycle
    if (clear_watchdog_instruction_instr || halt_instr)
      flags_nxt[FLAG_TO] = 1'b0; // [RULE8]
    if (wdt_expired)
      flags_nxt[FLAG_TO] = 1'b1; // [RULE8]
    if (clear_watchdog_instruction_instr)
      flags_nxt[FLAG_PDF] = 1'b0; // [RULE9]
    if (halt_instr)
      flags_nxt[FLAG_PDF] = 1'b1; // [RULE9]
  end

  // Flags are never pushed; calls see only this register
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      core_flags_reg <= FLAGS_RST; // [RULE8] [RULE9] [RULE12]
    else
      core_flags_reg <= flags_nxt;
  end

  // ALU results land only in the accumulator
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      acc_r <= 8'h00;
    else if (acc_write && flag_upd)
      acc_r <= result; // [RULE17]
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      program_bank_select_reg <= BANK_RST;
    else if (bank_wr)
      program_bank_select_reg <= {7'h00, bank_wdata[0]}; // [RULE13]
  end

  // PC low write: jump in page, then one dummy cycle of stall
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r       <= CSFP_ST_RUN;
      jump_r        <= 1'b0;
      jump_target_r <= 16'h0000;
      stall_r       <= 1'b0;
    end else begin
      jump_r <= 1'b0;
      unique case (state_r)
        CSFP_ST_RUN: begin
          stall_r <= 1'b0;
          if (pcl_wr) begin
            jump_r        <= 1'b1;
            jump_target_r <= {pc_high, pcl_wdata}; // [RULE14]
            stall_r       <= (JUMP_DUMMY != 2'h0);
            state_r       <= CSFP_ST_DUMMY;
          end
        end
        CSFP_ST_DUMMY: begin
          stall_r <= 1'b0; // [RULE14]
          state_r <= CSFP_ST_RUN;
        end
        default: state_r <= CSFP_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      table_pointer_low  <= 8'h00;
      table_pointer_high <= 8'h00;
    end else begin
      if (table_pointer_low_wr)
        table_pointer_low <= tbl_wdata;
      if (table_pointer_high_wr)
        table_pointer_high <= tbl_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      table_addr_r     <= 16'h0000;
      table_high_latch <= 8'h00;
      table_low_r      <= 8'h00;
      table_low_vld_r  <= 1'b0;
    end else begin
      table_addr_r    <= {table_pointer_high, table_pointer_low};
      table_low_vld_r <= tbl_read;
      if (tbl_read) begin
        table_high_latch <= prog_word[15:8]; // [RULE15]
        table_low_r      <= prog_word[7:0];  // [RULE15]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pointer_one_low  <= 8'h00;
      pointer_one_high <= 8'h00;
    end else begin
      if (ptr1l_wr)
        pointer_one_low <= ptr_wdata;
      if (ptr1h_wr)
        pointer_one_high <= ptr_wdata;
    end
  end

  // Data memory address: extended direct first, else indirect port one
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dmem_sector_r <= '0;
      dmem_loc_r    <= 8'h00;
      dmem_sel_r    <= 1'b0;
    end else begin
      dmem_sel_r <= ext_access | ind1_access;
      if (ext_access) begin
        dmem_sector_r <= ext_addr[SECT_W+7:8]; // [RULE16]
        dmem_loc_r    <= ext_addr[7:0];        // [RULE16]
      end else if (ind1_access) begin
        dmem_sector_r <= pointer_one_high[SECT_W-1:0]; // [RULE18]
        dmem_loc_r    <= pointer_one_low;              // [RULE18]
      end
    end
  end

  // Port is not physical; register-style reads give a constant
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ind_read_r <= IND_READ;
    else if (ind_as_reg_rd)
      ind_read_r <= IND_READ; // [RULE19]
  end
endmodule

// File: verif/csfp_chk_props.sv
// Checker for the status flags and pointers block.
// Assumes it is bound to csfp_core and sees only that module's ports.
`timescale 1ns/10ps
module csfp_chk
  import csfp_pkg::*;
#(
  parameter int SECT_W = 2
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire csfp_op_t          alu_op,
  input wire logic              acc_write,
  input wire logic              wdt_expired,
  input wire logic              clear_watchdog_instruction_instr,
  input wire logic              halt_instr,
  input wire logic              flags_wr,
  input wire logic              bank_wr,
  input wire logic [7:0]        bank_wdata,
  input wire logic              pcl_wr,
  input wire logic [7:0]        pcl_wdata,
  input wire logic [7:0]        pc_high,
  input wire logic              tbl_read,
  input wire logic [15:0]       prog_word,
  input wire logic              ext_access,
  input wire logic [SECT_W+7:0] ext_addr,
  input wire logic [7:0]        core_flags_reg,
  input wire logic [7:0]        program_bank_select_reg,
  input wire logic [7:0]        acc_r,
  input wire logic              jump_r,
  input wire logic [15:0]       jump_target_r,
  input wire logic              stall_r,
  input wire logic [7:0]        table_high_latch,
  input wire logic [7:0]        table_low_r,
  input wire logic [SECT_W-1:0] dmem_sector_r,
  input wire logic [7:0]        dmem_loc_r,
  input wire logic              dmem_sel_r,
  input wire logic [7:0]        ind_read_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_jump_target: assert property (
    pcl_wr && !stall_r |=> jump_r && stall_r &&
    jump_target_r == {$past(pc_high), $past(pcl_wdata)})
    else $error("jump target or pulse wrong");
  chk_jump_single: assert property (jump_r |=> !jump_r && !stall_r)
    else $error("jump pulse too long");
  chk_bank_write: assert property (
    bank_wr |=> program_bank_select_reg == ($past(bank_wdata) & 8'h01))
    else $error("bank select write wrong");
  chk_ind_zero: assert property (ind_read_r == 8'h00)
    else $error("indirect port read not zero");
  chk_wdt_set: assert property (
    wdt_expired |=> core_flags_reg[FLAG_TO])
    else $error("watchdog flag not set");
  chk_halt_sleep: assert property (
    halt_instr && !wdt_expired |=> core_flags_reg[5:4] == 2'b01)
    else $error("halt flags wrong");
  chk_clear_watchdog_instruction: assert property (
    clear_watchdog_instruction_instr && !halt_instr && !wdt_expired |=>
    core_flags_reg[5:4] == 2'b00)
    else $error("clear watchdog flags wrong");
  chk_sys_hold: assert property (
    !(wdt_expired || clear_watchdog_instruction_instr || halt_instr) |=>
    $stable(core_flags_reg[5:4]))
    else $error("system flags changed by write");
  chk_sign_xor: assert property (
    alu_op inside {CSFP_OP_ADD, CSFP_OP_SUB} && acc_write && !flags_wr |=>
    core_flags_reg[FLAG_SC] == (core_flags_reg[FLAG_OV] ^ acc_r[7]))
    else $error("sign xor flag wrong");
  chk_table_load: assert property (
    tbl_read |=> {table_high_latch, table_low_r} == $past(prog_word))
    else $error("table read data wrong");
  chk_ext_map: assert property (
    ext_access |=> dmem_sel_r &&
    {dmem_sector_r, dmem_loc_r} == $past(ext_addr))
    else $error("extended address split wrong");

  cov_jump: cover property (jump_r);
  cov_halt: cover property (halt_instr);
  cov_table: cover property (tbl_read);
  cov_logic: cover property (alu_op == CSFP_OP_LOG && acc_write);
endmodule

bind csfp_core csfp_chk #(.SECT_W(SECT_W)) u_chk (.*);

// File: verif/csfp_prog_mem.sv
// Program memory model answering table reads from the block.
// Assumes the table address is settled before the read is issued.
`timescale 1ns/10ps
module csfp_prog_mem #(
  parameter logic [15:0] KEY = 16'hA55A
) (
  input  wire logic [15:0] table_addr_r,
  output logic      [15:0] prog_word
);
  // Word tied to its address so a stale pointer shows
  assign prog_word = table_addr_r ^ KEY;
endmodule

// File: verif/tb_top.sv
// Testbench for the status flags and pointers block.
// Assumes csfp_core with its checker bound and the program memory model.
`timescale 1ns/10ps
module tb_top;
  import csfp_pkg::*;
  localparam logic [15:0] MEM_KEY = 16'hA55A;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  csfp_op_t    alu_op = CSFP_OP_NONE;
  logic [7:0]  opa = 8'h00, opb = 8'h00, flags_wdata = 8'h00;
  logic [7:0]  bank_wdata = 8'h00, pcl_wdata = 8'h00, pc_high = 8'h00;
  logic [7:0]  tbl_wdata = 8'h00, ptr_wdata = 8'h00;
  logic        acc_write = 1'b0, wdt_expired = 1'b0, clear_watchdog_instruction_instr = 1'b0;
  logic        halt_instr = 1'b0, flags_wr = 1'b0, bank_wr = 1'b0;
  logic        pcl_wr = 1'b0, table_pointer_low_wr = 1'b0, table_pointer_high_wr = 1'b0;
  logic        tbl_read = 1'b0, ptr1l_wr = 1'b0, ptr1h_wr = 1'b0;
  logic        ind1_access = 1'b0, ind_as_reg_rd = 1'b0, ext_access = 1'b0;
  logic [9:0]  ext_addr = 10'h000;
  logic [15:0] prog_word, jump_target_r, table_addr_r;
  logic [7:0]  core_flags_reg, program_bank_select_reg, acc_r;
  logic [7:0]  table_high_latch, table_low_r, dmem_loc_r, ind_read_r;
  logic [1:0]  dmem_sector_r;
  logic        jump_r, stall_r, table_low_vld_r, dmem_sel_r;
  logic [15:0] dmem_view;
  int          bad_count = 0;
  int          comparisons = 0;

  always #25 core_clk = ~core_clk;

  csfp_core #(.SECT_W(2)) DUT (.*);
  csfp_prog_mem #(.KEY(MEM_KEY)) u_mem (.*);

  // Packed view keeps the address checks on one line
  assign dmem_view = {3'h0, dmem_sel_r, 2'h0, dmem_sector_r, dmem_loc_r};

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reference flags; carry is the no-borrow sense in subtraction
  function automatic logic [15:0] calc(csfp_op_t o, logic [7:0] a, f);
    logic [7:0] b;
    logic       ci;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    logic [7:0] n;
    b = (o == CSFP_OP_SUB || o == CSFP_OP_SBC) ? ~8'h01 : 8'h01;
    ci = (o == CSFP_OP_ADC || o == CSFP_OP_SBC) ? f[0] : ~b[0];
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    l = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    n = {f[7:4], l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
    n[7] = n[3] ^ s[7];
    if (o == CSFP_OP_SUB) n[6] = n[2];
    if (o == CSFP_OP_SBC) n[6] = f[6] & n[2];
    if (o == CSFP_OP_RLC) return {a[6:0], f[0], f[7:1], a[7]};
    if (o == CSFP_OP_RRC) return {f[0], a[7:1], f[7:1], a[0]};
    if (o == CSFP_OP_LOG) return {a & 8'h01, f[7:3], a[0] == 1'b0, f[1:0]};
    if (o == CSFP_OP_MOV) return {a, f[7:3], a == 8'h00, f[1:0]};
    return {s[7:0], n};
  endfunction

  // Second operand fixed at one for arithmetic and logic ops so boundaries come from the first
  task automatic t_arith;
    csfp_op_t   ops [11] = '{CSFP_OP_ADD, CSFP_OP_ADD, CSFP_OP_ADC,
      CSFP_OP_SUB, CSFP_OP_SBC, CSFP_OP_SBC, CSFP_OP_SUB, CSFP_OP_RLC,
      CSFP_OP_RRC, CSFP_OP_LOG, CSFP_OP_MOV};
    logic [7:0] av [11] = '{8'h7F, 8'hFF, 8'h0E, 8'h01, 8'h10, 8'h01,
      8'h80, 8'h81, 8'h02, 8'hFE, 8'h5A};
    logic [7:0] fl;
    logic [15:0] e;
    logic [15:0] g;
    fl = 8'h00;
    for (int i = 0; i < 11; i++) begin
      e = calc(ops[i], av[i], fl);
      fl = e[7:0];
      @(posedge core_clk);
      alu_op <= ops[i];
      opa <= av[i];
      opb <= (ops[i] > CSFP_OP_LOG) ? av[i] : 8'h01;
      acc_write <= 1'b1;
      @(posedge core_clk);
      alu_op <= CSFP_OP_NONE;
      acc_write <= 1'b0;
      #1;
      g = {acc_r, core_flags_reg};
      chk("acc", e & 16'hFF00, g & 16'hFF00);
      chk("c_ac", e & 16'h0003, g & 16'h0003);
      chk("z_ov", e & 16'h000C, g & 16'h000C);
      chk("sc_cz", e & 16'h00F0, g & 16'h00F0);
    end
  endtask

  task automatic t_sys;
    @(posedge core_clk);
    wdt_expired <= 1'b1;
    @(posedge core_clk);
    wdt_expired <= 1'b0;
    flags_wr <= 1'b1;
    flags_wdata <= 8'hFF;
    @(posedge core_clk);
    halt_instr <= 1'b1;
    flags_wdata <= 8'h00;
    #1;
    chk("wr_ones", 16'h00EF, {8'h00, core_flags_reg});
    @(posedge core_clk);
    halt_instr <= 1'b0;
    flags_wr <= 1'b0;
    clear_watchdog_instruction_instr <= 1'b1;
    #1;
    chk("halt", 16'h0010, {8'h00, core_flags_reg});
    @(posedge core_clk);
    clear_watchdog_instruction_instr <= 1'b0;
    #1;
    chk("clear_watchdog_instruction", 16'h0000, {8'h00, core_flags_reg});
  endtask

  task automatic t_bank(logic [7:0] d);
    @(posedge core_clk);
    bank_wr <= 1'b1;
    bank_wdata <= d;
    @(posedge core_clk);
    bank_wr <= 1'b0;
    #1;
    chk("bank", 16'(d[0]), {8'h00, program_bank_select_reg});
  endtask

  // Write held into the dummy cycle must not jump again
  task automatic t_jump;
    @(posedge core_clk);
    pc_high <= 8'h12;
    pcl_wr <= 1'b1;
    pcl_wdata <= 8'h34;
    @(posedge core_clk);
    pcl_wdata <= 8'h56;
    #1;
    chk("jump_to", 16'h1234, jump_target_r);
    chk("jump", 16'h0003, {14'h0000, jump_r, stall_r});
    @(posedge core_clk);
    pcl_wr <= 1'b0;
    #1;
    chk("dummy", 16'h0000, {14'h0000, jump_r, stall_r});
    chk("jump_hold", 16'h1234, jump_target_r);
  endtask

  task automatic t_table;
    @(posedge core_clk);
    table_pointer_low_wr <= 1'b1;
    tbl_wdata <= 8'h3C;
    @(posedge core_clk);
    table_pointer_low_wr <= 1'b0;
    table_pointer_high_wr <= 1'b1;
    tbl_wdata <= 8'h01;
    @(posedge core_clk);
    table_pointer_high_wr <= 1'b0;
    @(posedge core_clk);
    tbl_read <= 1'b1;
    @(posedge core_clk);
    tbl_read <= 1'b0;
    #1;
    chk("tbl_addr", 16'h013C, table_addr_r);
    chk("tbl_dat", 16'h013C ^ MEM_KEY, {table_high_latch, table_low_r});
    chk("tbl_vld", 16'h0001, {15'h0000, table_low_vld_r});
  endtask

  task automatic t_dmem;
    @(posedge core_clk);
    ext_access <= 1'b1;
    ext_addr <= 10'h1F0;
    @(posedge core_clk);
    ext_access <= 1'b0;
    ptr1h_wr <= 1'b1;
    ptr_wdata <= 8'h02;
    #1;
    chk("ext", 16'h11F0, dmem_view);
    @(posedge core_clk);
    ptr1h_wr <= 1'b0;
    ptr1l_wr <= 1'b1;
    ptr_wdata <= 8'h55;
    @(posedge core_clk);
    ptr1l_wr <= 1'b0;
    ind1_access <= 1'b1;
    ind_as_reg_rd <= 1'b1;
    @(posedge core_clk);
    ind1_access <= 1'b0;
    ind_as_reg_rd <= 1'b0;
    #1;
    chk("ind", 16'h1255, dmem_view);
    chk("ind_rd", 16'h0000, {8'h00, ind_read_r});
  endtask

  // Mid-run reset must clear the sleep flag and bank bit as at power-up
  task automatic t_reset;
    @(posedge core_clk);
    halt_instr <= 1'b1;
    bank_wr <= 1'b1;
    bank_wdata <= 8'h01;
    @(posedge core_clk);
    halt_instr <= 1'b0;
    bank_wr <= 1'b0;
    sys_rst <= 1'b1;
    #1;
    chk("pre_rst", 16'h0010, {8'h00, core_flags_reg});
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst_flags2", 16'h0000, {8'h00, core_flags_reg});
    chk("rst_bank2", 16'h0000, {8'h00, program_bank_select_reg});
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst_flags", 16'h0000, {8'h00, core_flags_reg});
    chk("rst_bank", 16'h0000, {8'h00, program_bank_select_reg});
    t_arith();
    t_sys();
    t_bank(8'hFF);
    t_bank(8'hFE);
    t_jump();
    t_table();
    t_dmem();
    t_reset();
    complete_run();
  end

  // Whole run needs about 70 cycles
  initial begin
    repeat (400) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule
